// ==== verilog/hsp_consts.svh ====
// Constants of the host serial port: rates, dividers, reset values and limits.
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH

// Module clock: 10 MHz, one cycle every 100 ns.
`define HSP_CLK_HZ          10000000
`define HSP_CLK_PERIOD_NS   100
`define HSP_CLK_HZ_W        24'h989680

// Nominal rates of the eight table codes, in bits per second.
`define HSP_RATE_CODE0      1200
`define HSP_RATE_CODE1      2400
`define HSP_RATE_CODE2      4800
`define HSP_RATE_CODE3      9600
`define HSP_RATE_CODE4      19200
`define HSP_RATE_CODE5      38400
`define HSP_RATE_CODE6      57600
// Code 7 is nominally 115200 but really runs at this rate.
`define HSP_RATE_CODE7_REAL 111111

// Clocks per bit, rounded to the nearest whole cycle.
`define HSP_DIV_OF(r)       ((`HSP_CLK_HZ + (r) / 2) / (r))

// Setting range: codes up to 7, literal rates from 0x80 to 0x3d090.
`define HSP_RATE_CODE_MAX   18'h00007
`define HSP_RATE_LIT_MIN    18'h00080
`define HSP_RATE_LIT_MAX    18'h3d090
`define HSP_RATE_RESET      18'h00003

// Reset values of the other settings.
`define HSP_TIMEOUT_RESET   8'h03
`define HSP_PARITY_RESET    3'h0

// Largest radio packet, in bytes.
`define HSP_PKT_MAX         7'h64

// Character length in bit times without and with a parity bit.
`define HSP_CHAR_BITS       4'ha
`define HSP_CHAR_BITS_PAR   4'hb

// Host input buffer shape.
`define HSP_FIFO_WIDTH      8
`define HSP_FIFO_DEPTH      32

// Index of the last step of the shift-subtract divider, which runs 24 steps.
`define HSP_DIV_STEPS       5'h17

`endif

// ==== verilog/hsp_pkg.sv ====
// Types shared by the host serial port packetizer.
package hsp_pkg;

  // Operating style of the host port.
  typedef enum logic [1:0] {
    HSP_API_TRANSPARENT = 2'h0,
    HSP_API_FRAMED      = 2'h1,
    HSP_API_ESCAPED     = 2'h2
  } hsp_api_t;

  // Host port settings written together.
  typedef struct packed {
    logic [7:0] packetSilenceTimeout;
    hsp_api_t   frameApiSelect;
    logic [2:0] paritySetting;
  } hsp_cfg_t;

  // Receiver states.
  typedef enum logic [3:0] {
    HSP_RX_IDLE  = 4'h1,
    HSP_RX_START = 4'h2,
    HSP_RX_DATA  = 4'h4,
    HSP_RX_STOP  = 4'h8
  } hsp_rx_state_t;

  // Baud calculation states.
  typedef enum logic [2:0] {
    HSP_CALC_IDLE = 3'h1,
    HSP_CALC_RATE = 3'h2,
    HSP_CALC_BACK = 3'h4
  } hsp_calc_state_t;

endpackage : hsp_pkg

// ==== verilog/hsp_fifo.sv ====
// Host input buffer: flip-flop FIFO with valid and ready on both sides.
module hsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign inReady  = count_reg != (AW + 1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage is written only, never reset, to keep it plain flip-flops.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap because the depth is a power of two.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_reg <= pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule : hsp_fifo

// ==== verilog/hsp_packetizer.sv ====
// Host serial receiver, baud setting logic and radio packetizer.
`include "hsp_consts.svh"
module hsp_packetizer
  import hsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        serialRxPin,
  input  wire logic        cfgWrite,
  input  wire hsp_cfg_t    cfgIn,
  input  wire logic        rateWrite,
  input  wire logic [17:0] rateIn,
  input  wire logic        exitCmdDone,
  input  wire logic        radioReady,
  output logic             hostClearToSend_b,
  output logic [7:0]       radioData,
  output logic             radioValid,
  output logic             radioCommit,
  output logic [6:0]       radioLength,
  output logic [17:0]      rateStored,
  output logic             rateBusy,
  output logic             rateReject,
  output logic [16:0]      rateDivider,
  output hsp_cfg_t         cfgActive,
  output logic             framingError,
  output logic             overrun
);

  // Per-code clock divider; code 7 uses the slower real rate.
  function automatic logic [16:0] codeDivisor(input logic [2:0] code);
    case (code)
      3'h0:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE0));
      3'h1:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE1));
      3'h2:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE2));
      3'h3:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE3));
      3'h4:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE4));
      3'h5:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE5));
      3'h6:    codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE6));
      default: codeDivisor = 17'(`HSP_DIV_OF(`HSP_RATE_CODE7_REAL));
    endcase
  endfunction : codeDivisor

  logic            rstSync1_reg;
  logic            rstN;
  logic            rxMeta_reg;
  logic            rxPin_reg;
  hsp_cfg_t        cfg_reg;
  hsp_calc_state_t calc_reg;
  logic [23:0]     num_reg;
  logic [17:0]     den_reg;
  logic [17:0]     rem_reg;
  logic [23:0]     quo_reg;
  logic [4:0]      step_reg;
  logic [16:0]     pendDiv_reg;
  logic [16:0]     div_reg;
  logic            applyPend_reg;
  logic [17:0]     stored_reg;
  logic            reject_reg;
  hsp_rx_state_t   rx_reg;
  logic [16:0]     rxTick_reg;
  logic [3:0]      rxBit_reg;
  logic [7:0]      rxShift_reg;
  logic            rxDone_reg;
  logic            rxErr_reg;
  logic [16:0]     idleTick_reg;
  logic [3:0]      idleBits_reg;
  logic [7:0]      silence_reg;
  logic [6:0]      pktCount_reg;
  logic [7:0]      radioData_reg;
  logic            radioValid_reg;
  logic            commit_reg;
  logic [6:0]      length_reg;
  logic            overrun_reg;
  logic            cts_b_reg;
  logic            fifoInReady;
  logic            fifoOutValid;
  logic [7:0]      fifoOutData;
  logic            take;

  // Reset is released through two flops so every flop leaves reset together.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_reg <= 1'b0;
      rstN         <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN         <= rstSync1_reg;
    end
  end

  // The receive pin is asynchronous; only the second flop is read.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxMeta_reg <= 1'b1;
      rxPin_reg  <= 1'b1;
    end else begin
      rxMeta_reg <= serialRxPin;
      rxPin_reg  <= rxMeta_reg;
    end
  end

  // Settings take effect at once; parity only stretches the character.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfg_reg.packetSilenceTimeout <= `HSP_TIMEOUT_RESET;
      cfg_reg.frameApiSelect       <= HSP_API_TRANSPARENT;
      cfg_reg.paritySetting        <= `HSP_PARITY_RESET;
    end else if (cfgWrite) begin
      cfg_reg <= cfgIn;
    end
  end

  // Rate setting classification and one shift-subtract divider step.
  logic        rateIsCode;
  logic        rateIsLit;
  logic [18:0] divShift;
  logic        divGe;
  logic [23:0] quoNext;
  logic        stepLast;
  assign rateIsCode = rateIn <= `HSP_RATE_CODE_MAX;
  assign rateIsLit  = rateIn >= `HSP_RATE_LIT_MIN && rateIn <= `HSP_RATE_LIT_MAX;
  assign divShift   = {rem_reg, num_reg[23]};
  assign divGe      = divShift >= {1'b0, den_reg};
  assign quoNext    = {quo_reg[22:0], divGe};
  assign stepLast   = step_reg == `HSP_DIV_STEPS;

  // Literal rates take two divisions: clocks per bit, then the rate that
  // divider really gives. Rounding both ways keeps the stored value honest.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      calc_reg    <= HSP_CALC_IDLE;
      num_reg     <= '0;
      den_reg     <= '0;
      rem_reg     <= '0;
      quo_reg     <= '0;
      step_reg    <= '0;
      pendDiv_reg <= 17'(`HSP_DIV_OF(`HSP_RATE_CODE3));
      stored_reg  <= `HSP_RATE_RESET;
      reject_reg  <= 1'b0;
    end else begin
      reject_reg <= 1'b0;
      case (calc_reg)
        HSP_CALC_IDLE: begin
          rem_reg  <= '0;
          step_reg <= '0;
          if (rateWrite && rateIsCode) begin
            pendDiv_reg <= codeDivisor(rateIn[2:0]);
            stored_reg  <= rateIn;
          end else if (rateWrite && rateIsLit) begin
            num_reg  <= `HSP_CLK_HZ_W + 24'(rateIn >> 1);
            den_reg  <= rateIn;
            calc_reg <= HSP_CALC_RATE;
          end else if (rateWrite) begin
            reject_reg <= 1'b1;
          end
        end
        HSP_CALC_RATE, HSP_CALC_BACK: begin
          rem_reg  <= divGe ? 18'(divShift - {1'b0, den_reg}) : divShift[17:0];
          num_reg  <= {num_reg[22:0], 1'b0};
          quo_reg  <= quoNext;
          step_reg <= step_reg + 5'h01;
          if (stepLast && calc_reg == HSP_CALC_RATE) begin
            pendDiv_reg <= quoNext[16:0];
            num_reg     <= `HSP_CLK_HZ_W + 24'(quoNext[16:1]);
            den_reg     <= {1'b0, quoNext[16:0]};
            rem_reg     <= '0;
            step_reg    <= '0;
            calc_reg    <= HSP_CALC_BACK;
          end else if (stepLast) begin
            stored_reg <= quoNext[17:0];
            calc_reg   <= HSP_CALC_IDLE;
          end
        end
        default: calc_reg <= HSP_CALC_IDLE;
      endcase
    end
  end

  // The divider in use changes only after the exit acknowledge, and only
  // once any calculation has finished; a new request wins over the clear.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      applyPend_reg <= 1'b0;
      div_reg       <= 17'(`HSP_DIV_OF(`HSP_RATE_CODE3));
    end else begin
      applyPend_reg <= exitCmdDone || (applyPend_reg && calc_reg != HSP_CALC_IDLE);
      if (applyPend_reg && calc_reg == HSP_CALC_IDLE) begin
        div_reg <= pendDiv_reg;
      end
    end
  end

  // Receiver timing: half a bit to the start centre, then whole bits.
  logic        rxTickDone;
  logic [3:0]  rxLastBit;
  logic [3:0]  charBits;
  assign rxTickDone = rxTick_reg == '0;
  assign rxLastBit  = cfg_reg.paritySetting == 3'h0 ? 4'h7 : 4'h8;
  assign charBits   = cfg_reg.paritySetting == 3'h0 ? `HSP_CHAR_BITS : `HSP_CHAR_BITS_PAR;

  // Eight data bits LSB first; a parity bit, if present, is skipped unread.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rx_reg      <= HSP_RX_IDLE;
      rxTick_reg  <= '0;
      rxBit_reg   <= '0;
      rxShift_reg <= '0;
      rxDone_reg  <= 1'b0;
      rxErr_reg   <= 1'b0;
    end else begin
      rxDone_reg <= 1'b0;
      rxErr_reg  <= 1'b0;
      rxTick_reg <= rxTickDone ? div_reg - 17'h00001 : rxTick_reg - 17'h00001;
      case (rx_reg)
        HSP_RX_IDLE: if (!rxPin_reg) begin
          rxTick_reg <= {1'b0, div_reg[16:1]};
          rx_reg     <= HSP_RX_START;
        end
        HSP_RX_START: if (rxTickDone) begin
          rxBit_reg <= '0;
          rx_reg    <= rxPin_reg ? HSP_RX_IDLE : HSP_RX_DATA;
        end
        HSP_RX_DATA: if (rxTickDone) begin
          if (rxBit_reg[3] == 1'b0) begin
            rxShift_reg <= {rxPin_reg, rxShift_reg[7:1]};
          end
          rxBit_reg <= rxBit_reg + 4'h1;
          rx_reg    <= rxBit_reg == rxLastBit ? HSP_RX_STOP : HSP_RX_DATA;
        end
        HSP_RX_STOP: if (rxTickDone) begin
          rxDone_reg <= rxPin_reg;
          rxErr_reg  <= !rxPin_reg;
          rx_reg     <= HSP_RX_IDLE;
        end
        default: rx_reg <= HSP_RX_IDLE;
      endcase
    end
  end

  // Silence is measured in whole character times while the line idles high.
  logic lineIdle;
  assign lineIdle = rx_reg == HSP_RX_IDLE && rxPin_reg;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      idleTick_reg <= '0;
      idleBits_reg <= '0;
      silence_reg  <= '0;
    end else if (!lineIdle) begin
      idleTick_reg <= div_reg - 17'h00001;
      idleBits_reg <= '0;
      silence_reg  <= '0;
    end else if (idleTick_reg == '0) begin
      idleTick_reg <= div_reg - 17'h00001;
      idleBits_reg <= idleBits_reg == charBits - 4'h1 ? 4'h0 : idleBits_reg + 4'h1;
      if (idleBits_reg == charBits - 4'h1 && silence_reg != 8'hff) begin
        silence_reg <= silence_reg + 8'h01;
      end
    end else begin
      idleTick_reg <= idleTick_reg - 17'h00001;
    end
  end

  // The buffer cannot stall the line, so a byte meeting a full buffer is
  // dropped and flagged; the host is asked to pause before that happens.
  hsp_fifo #(
    .WIDTH (`HSP_FIFO_WIDTH),
    .DEPTH (`HSP_FIFO_DEPTH)
  ) u_host_input_buffer (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (rxDone_reg),
    .inData   (rxShift_reg),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (take)
  );

  // Packet decisions; framed styles leave packet boundaries to the frames.
  logic transparent;
  logic pktFull;
  logic drained;
  logic silenceMet;
  logic commitNow;
  assign transparent = cfg_reg.frameApiSelect == HSP_API_TRANSPARENT;
  assign pktFull     = transparent && pktCount_reg == `HSP_PKT_MAX;
  assign drained     = !fifoOutValid && !radioValid_reg;
  assign silenceMet  = cfg_reg.packetSilenceTimeout == 8'h00
                    || silence_reg >= cfg_reg.packetSilenceTimeout;
  // The radio side paces itself by its own ready, never by the baud rate.
  assign take        = fifoOutValid && !pktFull && (!radioValid_reg || radioReady);
  assign commitNow   = transparent && pktCount_reg != 7'h00
                    && (pktFull ? !radioValid_reg : drained && silenceMet);

  // Output stage and packet byte count.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      radioData_reg  <= '0;
      radioValid_reg <= 1'b0;
      pktCount_reg   <= '0;
      commit_reg     <= 1'b0;
      length_reg     <= '0;
    end else begin
      commit_reg <= commitNow;
      if (take) begin
        radioData_reg  <= fifoOutData;
        radioValid_reg <= 1'b1;
      end else if (radioReady) begin
        radioValid_reg <= 1'b0;
      end
      if (commitNow) begin
        length_reg   <= pktCount_reg;
        pktCount_reg <= '0;
      end else if (take && transparent) begin
        pktCount_reg <= pktCount_reg + 7'h01;
      end
    end
  end

  // Flow control toward the host: pause while the buffer is full.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      overrun_reg <= 1'b0;
      cts_b_reg   <= 1'b0;
    end else begin
      overrun_reg <= rxDone_reg && !fifoInReady;
      cts_b_reg   <= !fifoInReady;
    end
  end

  // Every output is a flop except rateBusy, decoded from the calculation state.
  assign hostClearToSend_b = cts_b_reg;
  assign radioData         = radioData_reg;
  assign radioValid        = radioValid_reg;
  assign radioCommit       = commit_reg;
  assign radioLength       = length_reg;
  assign rateStored        = stored_reg;
  assign rateBusy          = calc_reg != HSP_CALC_IDLE;
  assign rateReject        = reject_reg;
  assign rateDivider       = div_reg;
  assign cfgActive         = cfg_reg;
  assign framingError      = rxErr_reg;
  assign overrun           = overrun_reg;

endmodule : hsp_packetizer

// ==== bench/hsp_packetizer_asserts.sv ====
// Concurrent checks on the ports of the host serial port packetizer.
`include "hsp_consts.svh"
module hsp_packetizer_asserts
  import hsp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cfgWrite,
  input wire hsp_cfg_t    cfgIn,
  input wire logic        rateWrite,
  input wire logic [17:0] rateIn,
  input wire logic        exitCmdDone,
  input wire logic        radioReady,
  input wire logic        hostClearToSend_b,
  input wire logic [7:0]  radioData,
  input wire logic        radioValid,
  input wire logic        radioCommit,
  input wire logic [6:0]  radioLength,
  input wire logic [17:0] rateStored,
  input wire logic        rateBusy,
  input wire logic        rateReject,
  input wire logic [16:0] rateDivider,
  input wire hsp_cfg_t    cfgActive,
  input wire logic        overrun
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Cycles since the last exit command; it saturates so that a late divider change shows.
  logic [7:0] sinceExit_reg;
  logic [7:0] sinceExit_next;
  logic       rateTake;
  assign rateTake = rateWrite && !rateBusy;
  assign sinceExit_next = exitCmdDone ? 8'h00 :
                          (sinceExit_reg == 8'hff ? 8'hff : sinceExit_reg + 8'h01);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sinceExit_reg <= 8'hff;
    else sinceExit_reg <= sinceExit_next;
  end

  // Rate setting: codes store at once, bad values are refused, literals take 48 cycles.
  AST_CODE_STORE: assert property (rateTake && rateIn <= `HSP_RATE_CODE_MAX |=>
    rateStored == $past(rateIn) && !rateBusy) else $error("code not stored at once");
  AST_RATE_REFUSE: assert property (rateTake && (rateIn > `HSP_RATE_CODE_MAX &&
    rateIn < `HSP_RATE_LIT_MIN || rateIn > `HSP_RATE_LIT_MAX) |=>
    rateReject && $stable(rateStored)) else $error("bad rate not refused");
  AST_LIT_CALC: assert property (rateTake &&
    rateIn inside {[`HSP_RATE_LIT_MIN:`HSP_RATE_LIT_MAX]} |=>
    (!rateReject && rateBusy) ##1 rateBusy [*7] ##40 rateBusy ##1 !rateBusy)
    else $error("bad calc span");
  // The divider may only move shortly after an exit command, never on its own.
  AST_DIV_AFTER_EXIT: assert property ($changed(rateDivider) |->
    sinceExit_reg < 8'd60) else $error("divider moved without exit");
  AST_CFG_LOAD: assert property (cfgWrite |=> cfgActive == $past(cfgIn))
    else $error("settings not loaded");
  // Packet commits are single pulses with a length of one to a full packet.
  AST_COMMIT_PULSE: assert property (radioCommit |->
    radioLength != 7'h00 && radioLength <= `HSP_PKT_MAX ##1 !radioCommit)
    else $error("bad commit");
  AST_FRAMED_QUIET: assert property (cfgActive.frameApiSelect != HSP_API_TRANSPARENT &&
    $stable(cfgActive.frameApiSelect) |-> !radioCommit) else $error("commit in framed mode");
  AST_VALID_HOLD: assert property (radioValid && !radioReady |=>
    radioValid && $stable(radioData)) else $error("radio byte not held");
  // The host must already have been told to pause when a byte is lost.
  AST_OVERRUN_CTS: assert property (overrun |-> $past(hostClearToSend_b))
    else $error("byte lost while host was not held off");

  COV_COMMIT: cover property (radioCommit);
  COV_OVERRUN: cover property (overrun);
  COV_REFUSE: cover property (rateTake ##1 rateReject);
endmodule : hsp_packetizer_asserts

// ==== bench/hsp_host_model.sv ====
// Host controller model: drives characters onto the serial line of the port.
module hsp_host_model (
  input  wire logic clk,
  input  wire logic ctsB,
  output logic      txLine
);
  timeunit 1ns;
  timeprecision 100ps;
  bit ignoreCts;

  // The host line idles high between characters.
  initial begin
    txLine = 1'b1;
    ignoreCts = 1'b0;
  end

  // One bit time; the line only changes at falling edges.
  task automatic bitOut(input logic v, input int div);
    txLine = v;
    repeat (div) @(negedge clk);
  endtask : bitOut

  // One character: start, eight data bits low first, an optional unchecked bit, stop.
  task automatic send(input logic [7:0] b, input int div, input bit par, input bit badStop);
    int w;
    w = 0;
    while (ctsB && !ignoreCts && w < 100000) begin
      @(negedge clk);
      w++;
    end
    @(negedge clk);
    bitOut(1'b0, div);
    for (int i = 0; i < 8; i++) bitOut(b[i], div);
    if (par) bitOut(~^b, div);
    bitOut(!badStop, div);
    txLine = 1'b1;
  endtask : send
endmodule : hsp_host_model

// ==== bench/hsp_packetizer_bench.sv ====
// Self-checking bench of the host serial port packetizer.
module hsp_packetizer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import hsp_pkg::*;
  logic        clk, rst_b, serialRxPin, cfgWrite, rateWrite, exitCmdDone, radioReady;
  logic        hostClearToSend_b, radioValid, radioCommit, rateBusy, rateReject;
  logic        framingError, overrun, rejSeen;
  hsp_cfg_t    cfgIn, cfgActive;
  logic [17:0] rateIn, rateStored;
  logic [16:0] rateDivider;
  logic [7:0]  radioData;
  logic [6:0]  radioLength, lastLen;
  logic [7:0]  rxq[$];
  int          nMismatch, numChecks, commits, ovr, ferr;
  int          divTab[8] = '{8333, 4167, 2083, 1042, 521, 260, 174, 90};
  logic [17:0] litIn[4] = '{18'h0012c, 18'h1c200, 18'h00080, 18'h3d090};
  logic [17:0] litSt[4] = '{18'h0012c, 18'h1c0ff, 18'h00080, 18'h3d090};
  int          litDiv[4] = '{33333, 87, 78125, 40};
  localparam int LitDiv = 40;

  hsp_packetizer hsp_packetizer_i (.clk, .rst_b, .serialRxPin, .cfgWrite, .cfgIn, .rateWrite,
    .rateIn, .exitCmdDone, .radioReady, .hostClearToSend_b, .radioData, .radioValid,
    .radioCommit, .radioLength, .rateStored, .rateBusy, .rateReject, .rateDivider, .cfgActive,
    .framingError, .overrun);
  hsp_host_model hsp_host_model_i (.clk, .ctsB(hostClearToSend_b), .txLine(serialRxPin));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Records what reaches the radio side at each rising edge.
  always @(posedge clk) begin
    if (radioValid && radioReady) rxq.push_back(radioData);
    if (radioCommit) begin
      commits++;
      lastLen = radioLength;
    end
    if (overrun) ovr++;
    if (framingError) ferr++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic endOfTest();
    if (nMismatch == 0 && numChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : endOfTest

  // A rate write is taken once; the refuse pulse is caught one cycle later.
  task automatic setRate(input logic [17:0] v);
    int w;
    w = 0;
    @(negedge clk);
    rateWrite = 1'b1;
    rateIn = v;
    @(negedge clk);
    rateWrite = 1'b0;
    rejSeen = rateReject;
    while (rateBusy !== 1'b0 && w < 200) begin
      @(negedge clk);
      w++;
    end
  endtask : setRate

  task automatic applyRate();
    @(negedge clk);
    exitCmdDone = 1'b1;
    @(negedge clk);
    exitCmdDone = 1'b0;
    repeat (3) @(negedge clk);
  endtask : applyRate

  task automatic setCfg(input logic [7:0] to, input hsp_api_t api, input logic [2:0] par);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgIn = {to, api, par};
    @(negedge clk);
    cfgWrite = 1'b0;
    check(cfgActive, {to, api, par});
    rxq.delete();
    commits = 0;
    ovr = 0;
    ferr = 0;
  endtask : setCfg

  task automatic sendN(input int n, input logic [7:0] first, input bit par);
    for (int i = 0; i < n; i++) hsp_host_model_i.send(first + i[7:0], LitDiv, par, 1'b0);
  endtask : sendN

  // Watchdog: the whole sequence needs some 65000 cycles.
  initial begin
    repeat (95000) @(posedge clk);
    nMismatch++;
    endOfTest();
  end

  initial begin
    {rst_b, cfgWrite, rateWrite, exitCmdDone, cfgIn, rateIn} = '0;
    radioReady = 1'b1;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check(rateStored, 32'h3);
    check(rateDivider, 32'd1042);
    check(cfgActive, {8'h03, HSP_API_TRANSPARENT, 3'h0});
    check(hostClearToSend_b, 1'b0);
    // Codes store at once, but the divider waits for the exit command.
    for (int k = 0; k < 8; k++) begin
      setRate(18'(k));
      check(rateStored, 32'(k));
      check(rateDivider, 32'(k == 0 ? 1042 : divTab[k - 1]));
      applyRate();
      check(rateDivider, 32'(divTab[k]));
    end
    check(rateDivider, 32'd90);
    // Values between the code and literal ranges, or above it, are refused.
    foreach (litSt[j]) begin
      setRate(j == 0 ? 18'h00008 : (j == 1 ? 18'h0007f : 18'h3d091));
      check(rejSeen, 1'b1);
      check(rateStored, 32'h7);
    end
    // Literal rates, ending at the fastest one used for the traffic below.
    foreach (litIn[j]) begin
      setRate(litIn[j]);
      check(rejSeen, 1'b0);
      check(rateStored, litSt[j]);
      applyRate();
      check(rateDivider, 32'(litDiv[j]));
    end
    setCfg(8'h00, HSP_API_TRANSPARENT, 3'h0);
    sendN(3, 8'ha5, 1'b0);
    repeat (200) @(negedge clk);
    check(32'(rxq.size()), 32'd3);
    check(commits, 32'd3);
    check(lastLen, 7'h01);
    check(rxq[2], 8'ha7);
    // Three character times of silence are needed, two are not enough.
    setCfg(8'h03, HSP_API_TRANSPARENT, 3'h0);
    sendN(5, 8'h10, 1'b0);
    repeat (800) @(negedge clk);
    check(commits, 32'd0);
    repeat (800) @(negedge clk);
    check(commits, 32'd1);
    check(lastLen, 7'h05);
    setCfg(8'hff, HSP_API_TRANSPARENT, 3'h0);
    sendN(100, 8'h00, 1'b0);
    repeat (50) @(negedge clk);
    check(commits, 32'd1);
    check(lastLen, 7'h64);
    // Parity values 1 to 4 each add one unchecked bit; framed styles never commit.
    for (int p = 1; p < 5; p++) begin
      setCfg(8'h00, hsp_api_t'(2'(p % 2 + 1)), 3'(p));
      sendN(1, 8'h3c + p[7:0], 1'b1);
      repeat (20) @(negedge clk);
      check(32'(rxq.size()), 32'd1);
      check(rxq[0], 8'h3c + p[7:0]);
      check(commits, 32'd0);
    end
    setCfg(8'h00, HSP_API_FRAMED, 3'h0);
    hsp_host_model_i.send(8'h81, LitDiv, 1'b0, 1'b1);
    repeat (400) @(negedge clk);
    check(ferr, 32'd1);
    check(32'(rxq.size()), 32'd0);
    // Radio stalls while the host overfills the buffer, then everything kept drains.
    setCfg(8'h00, HSP_API_FRAMED, 3'h0);
    radioReady = 1'b0;
    hsp_host_model_i.ignoreCts = 1'b1;
    sendN(36, 8'h40, 1'b0);
    repeat (20) @(negedge clk);
    check(hostClearToSend_b, 1'b1);
    // One byte waits in the output stage and 32 fill the buffer, so three are lost.
    check(ovr, 32'd3);
    radioReady = 1'b1;
    repeat (100) @(negedge clk);
    check(32'(rxq.size()), 32'd33);
    check(rxq[0], 8'h40);
    check(hostClearToSend_b, 1'b0);
    endOfTest();
  end
endmodule : hsp_packetizer_bench

bind hsp_packetizer hsp_packetizer_asserts hsp_packetizer_asserts_i (.clk, .rst_b, .cfgWrite,
  .cfgIn, .rateWrite, .rateIn, .exitCmdDone, .radioReady, .hostClearToSend_b, .radioData,
  .radioValid, .radioCommit, .radioLength, .rateStored, .rateBusy, .rateReject, .rateDivider,
  .cfgActive, .overrun);
